/* acr_pkg.sv */
// constants, register map and carrier types for the converter control block
//
// Summary of operation
// [R1] result equals input times 1024 over reference
// [R2] result held in byte registers once done
// [R3] channel 1000 routes and enables temperature sensor
// [R4] software uses 1.1V reference, single mode
// [R5] reference select decode in bits 7:6
// [R6] reference/channel changes apply after current conversion
// [R7] left adjust bit 5 reshapes view immediately
// [R8] multiplexer register bit 4 reads zero
// [R9] four-bit channel select decode
// [R10] enable bit powers converter; clearing aborts conversion
// [R11] start bit begins conversion; single/free running
// [R12] first conversion 25 cycles, later 13
// [R13] start bit reads one while busy
// [R14] auto trigger starts on selected rising edge
// [R15] done flag sets on completion, requests interrupt; a completion during the low byte read lock leaves it clear
// [R16] flag cleared by vector or writing one
// [R17] software avoids read-modify-write on control register
// [R18] done interrupt enable gates completion interrupt
// [R19] prescaler select divides system clock
// [R20] right adjusted byte layout
// [R21] left adjusted byte layout
// [R22] low byte read locks updates until high
// [R23] trigger source zero means free running
// [R24] result, flag, start bit change together; a single conversion ending under the read lock clears only the start bit
package acr_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_RESULT_LOW = 10'h078;
    localparam logic [9:0] IDX_RESULT_HIGH = 10'h079;
    localparam logic [9:0] IDX_CONTROL_STATUS = 10'h07A;
    localparam logic [9:0] IDX_CONTROL_B = 10'h07B;
    localparam logic [9:0] IDX_MUX_REF = 10'h07C;

    localparam int RESULT_BITS = 10;
    localparam logic [RESULT_BITS-1:0] RESULT_MSB_MASK = 10'h200;
    localparam logic [4:0] LEN_FIRST = 5'h19;
    localparam logic [4:0] LEN_NORMAL = 5'h0D;
    localparam logic [4:0] SAR_STEPS = 5'h0A;

    localparam logic [3:0] CH_TEMP_SENSOR = 4'h8;
    localparam logic [3:0] CH_BANDGAP = 4'hE;
    localparam logic [3:0] CH_GROUND = 4'hF;
    localparam logic [1:0] REF_EXTERNAL_PIN = 2'h0;
    localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
    localparam logic [1:0] REF_INTERNAL_1V1 = 2'h3;
    localparam logic [2:0] TRIG_FREE_RUNNING = 3'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic {
        ACR_IDLE = 1'b0,
        ACR_CONVERT = 1'b1
    } acr_state_t;

    typedef struct packed {
        logic [1:0] reference_select;
        logic left_adjust_result;
        logic [3:0] channel_select;
    } acr_mux_t;

    typedef struct packed {
        logic converter_enable;
        logic auto_trigger_enable;
        logic conversion_done_flag;
        logic done_interrupt_enable;
        logic [2:0] clock_divider_select;
        logic [2:0] trigger_source_select;
    } acr_ctrl_t;

    // toward the analog multiplexer, reference and comparator
    typedef struct packed {
        logic power_on;
        logic temp_sensor_enable;
        logic internal_ref_on;
        logic [1:0] reference_applied;
        logic [3:0] channel_applied;
        logic sample_strobe;
        logic [RESULT_BITS-1:0] trial_code;
    } acr_analog_t;

endpackage

/* acr_adc_ctrl.sv */
// control, prescaler, successive approximation sequencing and result registers
`timescale 1ns/1ps
module acr_adc_ctrl #(
    parameter int ADDR_W = 12
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator: high when input is at or above the trial code
    input wire logic comp_above_trial,
    // auto trigger sources, index 0 unused
    input wire logic [7:0] trigger_in,
    // cpu interrupt side
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic done_irq,
    // analog side
    output acr_pkg::acr_analog_t analog,
    output logic conversion_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        acr_pkg::acr_state_t state;
        acr_pkg::acr_mux_t mux;
        acr_pkg::acr_ctrl_t ctrl;
        logic [acr_pkg::RESULT_BITS-1:0] result;
        logic [acr_pkg::RESULT_BITS-1:0] sar;
        logic [acr_pkg::RESULT_BITS-1:0] bit_mask;
        logic [4:0] cycle;
        logic [4:0] length;
        logic init_pending;
        logic read_lock;
        logic trig_prev;
        logic [6:0] prescale;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        acr_pkg::acr_analog_t analog;
    } acr_regs_t;

    acr_regs_t state_reg;
    acr_regs_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // low bits of prescale counter that must all be ones for a tick
    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        logic [6:0] m;
        m = 7'h00;
        unique case (sel)
            3'h0, 3'h1: m = 7'h01;
            3'h2: m = 7'h03;
            3'h3: m = 7'h07;
            3'h4: m = 7'h0F;
            3'h5: m = 7'h1F;
            3'h6: m = 7'h3F;
            3'h7: m = 7'h7F;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] read_byte(input acr_regs_t s, input logic [9:0] idx);
        logic [7:0] d;
        d = acr_pkg::RESET_BYTE;
        unique case (idx)
            acr_pkg::IDX_RESULT_LOW: begin
                if (s.mux.left_adjust_result) begin
                    d = {s.result[1:0], 6'h00}; // R21 R7
                end else begin
                    d = s.result[7:0]; // R20
                end
            end
            acr_pkg::IDX_RESULT_HIGH: begin
                if (s.mux.left_adjust_result) begin
                    d = s.result[9:2]; // R21 R7
                end else begin
                    d = {6'h00, s.result[9:8]}; // R20
                end
            end
            acr_pkg::IDX_CONTROL_STATUS: begin
                d = {s.ctrl.converter_enable, s.state == acr_pkg::ACR_CONVERT, // R13
                     s.ctrl.auto_trigger_enable, s.ctrl.conversion_done_flag,
                     s.ctrl.done_interrupt_enable, s.ctrl.clock_divider_select};
            end
            acr_pkg::IDX_CONTROL_B: begin
                d = {5'h00, s.ctrl.trigger_source_select};
            end
            acr_pkg::IDX_MUX_REF: begin
                d = {s.mux.reference_select, s.mux.left_adjust_result, 1'b0, // R8
                     s.mux.channel_select};
            end
            default: d = acr_pkg::RESET_BYTE;
        endcase
        return d;
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx == acr_pkg::IDX_RESULT_LOW || idx == acr_pkg::IDX_RESULT_HIGH ||
               idx == acr_pkg::IDX_CONTROL_STATUS || idx == acr_pkg::IDX_CONTROL_B ||
               idx == acr_pkg::IDX_MUX_REF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [9:0] reg_idx;
    assign reg_idx = paddr[11:2];

    always_comb begin
        logic setup;
        logic access;
        logic tick;
        logic done;
        logic start_req;
        logic trig_sel;
        logic [4:0] cyc_inc;
        logic [acr_pkg::RESULT_BITS-1:0] decided;
        setup = 1'b0;
        access = 1'b0;
        tick = 1'b0;
        done = 1'b0;
        start_req = 1'b0;
        trig_sel = 1'b0;
        cyc_inc = 5'h00;
        decided = '0;
        state_next = state_reg;
        state_next.analog.sample_strobe = 1'b0;

        setup = psel && !penable;
        // pready is high for exactly the first access cycle: zero wait states
        access = psel && penable && state_reg.pready;

        // prescaler runs only while powered, so only the first conversion after enabling starts on a fresh count
        if (state_reg.ctrl.converter_enable) begin
            state_next.prescale = state_reg.prescale + 7'h01;
        end else begin
            state_next.prescale = 7'h00;
        end
        tick = (state_reg.prescale & div_mask(state_reg.ctrl.clock_divider_select)) ==
               div_mask(state_reg.ctrl.clock_divider_select); // R19

        // successive approximation: sample, ten decisions, then completion
        if (state_reg.state == acr_pkg::ACR_CONVERT && tick) begin
            cyc_inc = state_reg.cycle + 5'h01;
            state_next.cycle = cyc_inc;
            decided = state_reg.sar;
            if (state_reg.bit_mask != '0) begin
                if (!comp_above_trial) begin
                    decided = state_reg.sar & ~state_reg.bit_mask; // R1
                end
                state_next.bit_mask = state_reg.bit_mask >> 1;
                state_next.sar = decided | (state_reg.bit_mask >> 1);
            end
            if (cyc_inc == state_reg.length - acr_pkg::SAR_STEPS - 5'h01) begin
                state_next.analog.sample_strobe = 1'b1;
                state_next.bit_mask = acr_pkg::RESULT_MSB_MASK;
                state_next.sar = acr_pkg::RESULT_MSB_MASK;
            end
            if (cyc_inc == state_reg.length) begin // R12
                done = 1'b1;
                state_next.state = acr_pkg::ACR_IDLE; // R24 R13
                // a locked result is dropped whole, flag included
                if (!state_reg.read_lock) begin
                    state_next.result = decided; // R2 R22 R24
                end
            end
        end

        // free running restarts on completion
        if (done && state_reg.ctrl.auto_trigger_enable &&
            state_reg.ctrl.trigger_source_select == acr_pkg::TRIG_FREE_RUNNING) begin
            start_req = 1'b1; // R23
        end

        // edge on the selected source; switching source can itself make the edge
        trig_sel = trigger_in[state_reg.ctrl.trigger_source_select];
        state_next.trig_prev = trig_sel;
        if (state_reg.ctrl.auto_trigger_enable &&
            state_reg.ctrl.trigger_source_select != acr_pkg::TRIG_FREE_RUNNING &&
            trig_sel && !state_reg.trig_prev) begin
            start_req = 1'b1; // R14 R23
        end

        // apb
        state_next.pready = setup;
        state_next.pslverr = setup && !is_mapped(reg_idx);
        if (setup && !pwrite) begin
            state_next.prdata = {24'h000000, read_byte(state_reg, reg_idx)};
        end
        if (access && pwrite && pstrb[0]) begin
            unique case (reg_idx)
                acr_pkg::IDX_MUX_REF: begin
                    state_next.mux.reference_select = pwdata[7:6]; // R5
                    state_next.mux.left_adjust_result = pwdata[5]; // R7
                    state_next.mux.channel_select = pwdata[3:0]; // R9
                end
                acr_pkg::IDX_CONTROL_STATUS: begin
                    state_next.ctrl.converter_enable = pwdata[7]; // R10
                    state_next.ctrl.auto_trigger_enable = pwdata[5];
                    state_next.ctrl.done_interrupt_enable = pwdata[3]; // R18
                    state_next.ctrl.clock_divider_select = pwdata[2:0]; // R19
                    if (pwdata[4]) begin
                        state_next.ctrl.conversion_done_flag = 1'b0; // R16
                    end
                    if (pwdata[6]) begin
                        start_req = 1'b1; // R11
                    end
                end
                acr_pkg::IDX_CONTROL_B: begin
                    state_next.ctrl.trigger_source_select = pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
        if (access && !pwrite) begin
            if (reg_idx == acr_pkg::IDX_RESULT_LOW) begin
                state_next.read_lock = 1'b1; // R22
            end else if (reg_idx == acr_pkg::IDX_RESULT_HIGH) begin
                state_next.read_lock = 1'b0; // R22
            end
        end
        if (irq_vector_ack) begin
            state_next.ctrl.conversion_done_flag = 1'b0; // R16
        end
        // set beats any clear in the same cycle
        if (done && !state_reg.read_lock) begin
            state_next.ctrl.conversion_done_flag = 1'b1; // R15 R24
        end

        // enable, abort and start
        if (state_next.ctrl.converter_enable && !state_reg.ctrl.converter_enable) begin
            state_next.init_pending = 1'b1; // R12
        end
        if (!state_next.ctrl.converter_enable) begin
            state_next.state = acr_pkg::ACR_IDLE; // R10
            state_next.bit_mask = '0;
        end else if (start_req && state_next.state == acr_pkg::ACR_IDLE) begin
            state_next.state = acr_pkg::ACR_CONVERT; // R11
            state_next.cycle = 5'h00;
            state_next.bit_mask = '0;
            state_next.length = state_next.init_pending ? acr_pkg::LEN_FIRST : acr_pkg::LEN_NORMAL; // R12
            state_next.init_pending = 1'b0;
        end

        // selection changes reach the analog side only between conversions
        if (state_reg.state == acr_pkg::ACR_IDLE || done) begin
            state_next.analog.reference_applied = state_next.mux.reference_select; // R6
            state_next.analog.channel_applied = state_next.mux.channel_select; // R6
        end
        state_next.analog.power_on = state_next.ctrl.converter_enable; // R10
        state_next.analog.temp_sensor_enable = state_next.ctrl.converter_enable &&
            state_next.analog.channel_applied == acr_pkg::CH_TEMP_SENSOR; // R3
        state_next.analog.internal_ref_on = state_next.ctrl.converter_enable &&
            state_next.analog.reference_applied == acr_pkg::REF_INTERNAL_1V1; // R5
        state_next.analog.trial_code = state_next.sar;
        state_next.irq = state_next.ctrl.conversion_done_flag &&
            state_next.ctrl.done_interrupt_enable && global_irq_enable; // R15 R18
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign done_irq = state_reg.irq;
    assign analog = state_reg.analog;
    assign conversion_busy = state_reg.state == acr_pkg::ACR_CONVERT;

endmodule

/* acr_adc_ctrl_monitor.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
module acr_adc_ctrl_monitor #(
    parameter int ADDR_W = 12
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter
    input wire logic comp_above_trial,
    input wire logic [7:0] trigger_in,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic done_irq,
    input wire acr_pkg::acr_analog_t analog,
    input wire logic conversion_busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    property p_zero_wait;
        psel && !penable |=> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    property p_refuse;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused read not zero");
    property p_ref_on;
        analog.internal_ref_on == (analog.power_on && analog.reference_applied == acr_pkg::REF_INTERNAL_1V1);
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("internal reference wrong");
    property p_temp;
        analog.power_on && analog.channel_applied == acr_pkg::CH_TEMP_SENSOR |-> analog.temp_sensor_enable;
    endproperty
    a_temp: assert property (p_temp) else $error("sensor not enabled");
    property p_mux_hold;
        conversion_busy && $past(conversion_busy) |-> $stable(analog.channel_applied) && $stable(analog.reference_applied);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("selection moved mid conversion");
    property p_busy_pow;
        conversion_busy |-> analog.power_on;
    endproperty
    a_busy_pow: assert property (p_busy_pow) else $error("busy while off");
    // an abort may cut the bit decisions short
    property p_strobe;
        analog.sample_strobe |-> conversion_busy ##1 (conversion_busy || !analog.power_on) [*8];
    endproperty
    a_strobe: assert property (p_strobe) else $error("conversion too short");
    property p_irq;
        $rose(done_irq) |-> $past(global_irq_enable) && $past(conversion_busy, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
endmodule

/* acr_analog_model.sv */
// comparator model of the analog side, comparing the live input code with no sample and hold
`timescale 1ns/1ps
module acr_analog_model (
    // clock
    input wire logic pclk,
    // block side
    input wire acr_pkg::acr_analog_t analog,
    input wire logic [9:0] vin_code,
    output logic comp_above_trial
);
    logic flip;
    initial flip = 1'b0;
    always @(posedge pclk) flip <= ~flip;
    // unpowered comparator gives no stable answer
    always_comb begin
        if (analog.power_on) begin
            comp_above_trial = vin_code >= analog.trial_code;
        end else begin
            comp_above_trial = flip;
        end
    end
endmodule

/* acr_adc_ctrl_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acr_adc_ctrl_tb;
    localparam logic [11:0] adr_lo = {acr_pkg::IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] adr_hi = {acr_pkg::IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] adr_cs = {acr_pkg::IDX_CONTROL_STATUS, 2'b00};
    localparam logic [11:0] adr_cb = {acr_pkg::IDX_CONTROL_B, 2'b00};
    localparam logic [11:0] adr_mx = {acr_pkg::IDX_MUX_REF, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic comp, gie, ack, done_irq, busy, lar;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, ch, chn;
    logic [7:0] trig;
    logic [9:0] vin, vold;
    logic [1:0] rf;
    acr_pkg::acr_analog_t analog;
    logic [32:0] expq[$];
    int n_mismatch, total_checks, n, c, dv;
    always #50 pclk = ~pclk;
    acr_adc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comp_above_trial(comp), .trigger_in(trig), .global_irq_enable(gie), .irq_vector_ack(ack),
        .done_irq(done_irq), .analog(analog), .conversion_busy(busy));
    acr_analog_model model (.pclk(pclk), .analog(analog), .vin_code(vin), .comp_above_trial(comp));
    ////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        check(33'(expq.size()), 33'h0);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= ($urandom() & 32'hFFFFFF00) | {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 8'h00);
    endtask
    task automatic wait_done(input int len, input int d);
        n = 0;
        while (busy === 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        check(33'(n <= len * d + 1 && n + d + 4 >= len * d), 33'h1);
    endtask
    task automatic wait_rise();
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check({pslverr, prdata}, expq.pop_front());
        end
    end
    initial begin
        repeat (50000) @(posedge pclk);
        check(33'h0, 33'h1);
        final_report();
    end
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h1;
        gie = 1'b0;
        ack = 1'b0;
        trig = 8'h00;
        vin = 10'h000;
        n_mismatch = 0;
        total_checks = 0;
        n = $urandom(3695);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(adr_lo, 33'h0);
        rd(adr_hi, 33'h0);
        rd(adr_cs, 33'h0);
        rd(adr_mx, 33'h0);
        rd(12'h100, {1'b1, 32'h0});
        apb(1'b1, adr_mx, 8'hFF);
        rd(adr_mx, 33'hEF);
        vin <= 10'($urandom());
        apb(1'b1, adr_mx, 8'h40);
        apb(1'b1, adr_cs, 8'hC0);
        wait_done(25, 2);
        rd(adr_cs, 33'h90);
        apb(1'b1, adr_cs, 8'h90);
        rd(adr_cs, 33'h80);
        for (int i = 0; i < 16; i++) begin
            c = i % 8;
            dv = (c < 2) ? 2 : (1 << c);
            ch = 4'(i);
            chn = ~ch;
            rf = (i == 8) ? acr_pkg::REF_INTERNAL_1V1 : 2'(i);
            lar = i[0];
            vin <= 10'($urandom());
            gie <= i[1];
            apb(1'b1, adr_mx, {rf, 2'b00, ch});
            repeat (2) @(posedge pclk);
            check(33'(analog.channel_applied), 33'(ch));
            check(33'(analog.reference_applied), 33'(rf));
            check(33'(analog.temp_sensor_enable), 33'(ch == acr_pkg::CH_TEMP_SENSOR));
            apb(1'b1, adr_cs, {5'b11001, 3'(c)});
            apb(1'b1, adr_mx, {rf, lar, 1'b0, chn});
            wait_done(13, dv);
            repeat (2) @(posedge pclk);
            check(33'(analog.channel_applied), 33'(chn));
            check(33'(done_irq), 33'(i[1]));
            rd(adr_lo, 33'(lar ? {vin[1:0], 6'h00} : vin[7:0]));
            rd(adr_hi, 33'(lar ? vin[9:2] : {6'h00, vin[9:8]}));
            ack <= 1'b1;
            @(posedge pclk);
            ack <= 1'b0;
            repeat (2) @(posedge pclk);
            check(33'(done_irq), 33'h0);
            rd(adr_cs, 33'(8'h88 | 8'(c)));
        end
        // a low byte read holds off the next result
        apb(1'b1, adr_mx, 8'h40);
        apb(1'b1, adr_cs, 8'hC0);
        wait_done(13, 2);
        rd(adr_lo, 33'(vin[7:0]));
        vold = vin;
        vin <= ~vin;
        // flag from the previous result cleared so a dropped completion shows
        apb(1'b1, adr_cs, 8'hD0);
        wait_done(13, 2);
        rd(adr_cs, 33'h80);
        apb(1'b1, adr_mx, 8'h60);
        rd(adr_hi, 33'(vold[9:2]));
        apb(1'b1, adr_cb, 8'h03);
        trig <= 8'($urandom() & 32'hF7);
        apb(1'b1, adr_cs, 8'hA0);
        trig <= trig | 8'h08;
        wait_rise();
        check(33'(busy), 33'h1);
        wait_done(13, 2);
        apb(1'b1, adr_cb, 8'h00);
        // busy never drops in free running; the interrupt marks the completion
        apb(1'b1, adr_cs, 8'hF8);
        n = 0;
        while (done_irq !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        check(33'(done_irq), 33'h1);
        check(33'(busy), 33'h1);
        apb(1'b1, adr_cs, 8'h07);
        check(33'(busy), 33'h0);
        apb(1'b1, adr_cs, 8'h40);
        check(33'(busy), 33'h0);
        final_report();
    end
endmodule

bind acr_adc_ctrl acr_adc_ctrl_monitor #(.ADDR_W(ADDR_W)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_above_trial(comp_above_trial), .trigger_in(trigger_in),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .done_irq(done_irq),
    .analog(analog), .conversion_busy(conversion_busy));
